//--- verification/lcai_top_props.sv
// Port checker for the channel alarm block.
// Assumes it is bound to lcai_top from the bench.
`timescale 1ns/1ps
module lcai_top_props #(
	parameter int NUM_CHAN = 8,
	parameter int PTR_W = 6
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Host port
	input wire lcai_pkg::lcai_host_req_type host_req,
	input wire logic [7:0] host_rdata,
	// Line side
	input wire lcai_pkg::lcai_alarm_in_type [NUM_CHAN-1:0] alarm_in,
	input wire logic [NUM_CHAN-1:0][PTR_W-1:0] fifo_wr_ptr,
	input wire logic [NUM_CHAN-1:0][PTR_W-1:0] fifo_rd_ptr,
	input wire logic [NUM_CHAN-1:0] transmit_clock,
	input wire logic [NUM_CHAN-1:0] bit_error_flip,
	input wire logic irq
);
	logic [PTR_W-1:0] d_wr;
	logic [PTR_W-1:0] d_rd;
	logic near;
	assign d_wr = fifo_wr_ptr[0] - fifo_rd_ptr[0];
	assign d_rd = fifo_rd_ptr[0] - fifo_wr_ptr[0];
	assign near = (d_wr <= 3) || (d_rd <= 3);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence st_rd;
		$past(host_req.rd) && $past(host_req.addr) == 8'h05 && $past(rst_b, 2);
	endsequence
	a_flip_single: assert property (
		(bit_error_flip & $past(bit_error_flip)) == '0) else $error("flip long");
	a_flip_on_edge: assert property (
		(bit_error_flip & ~($past(transmit_clock) & ~$past(transmit_clock, 2)))
		== '0) else $error("flip without tx edge");
	a_status_live: assert property (
		st_rd ##0 $past(alarm_in[0]) == $past(alarm_in[0], 2) |->
		{host_rdata[6], host_rdata[2:0]} == $past({alarm_in[0].driver_fail,
		alarm_in[0].all_ones, alarm_in[0].signal_loss,
		alarm_in[0].pattern_detect}, 2)) else $error("status mismatch");
	a_fifo_flag: assert property (
		st_rd ##0 $past(near) == $past(near, 2) |->
		host_rdata[5] == $past(near, 2)) else $error("fifo flag wrong");
	a_unused_zero: assert property (
		$past(host_req.rd) && $past(host_req.addr[3:1]) == 3'h2 |->
		!host_rdata[7] && !host_rdata[3]) else $error("unused bit set");
	a_unmapped_zero: assert property (
		$past(host_req.rd) && $past(host_req.addr[7:4]) == 4'h9 |->
		host_rdata == 8'h00) else $error("unmapped read not zero");
	a_rdata_holds: assert property (
		!$past(host_req.rd) |-> $stable(host_rdata)) else $error("rdata moved");
	a_reset_clear: assert property (
		$rose(rst_b) |-> !irq && bit_error_flip == '0 && host_rdata == 8'h00)
		else $error("outputs not clear");
endmodule

//--- verification/tb_top.sv
// Self-checking bench for the channel alarm block.
// Assumes the package, header and design are compiled first.
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	lcai_pkg::lcai_host_req_type req = '0;
	logic [7:0] rdata;
	lcai_pkg::lcai_alarm_in_type [7:0] alarm = '0;
	logic [7:0][5:0] wp = '0;
	logic [7:0][5:0] rp = {8{6'h14}};
	logic [7:0] txc = '0;
	logic [7:0] flip;
	logic irq;
	int failures = 0;
	int n_compared = 0;
	int nflip = 0;
	logic [7:0] exp_st [6] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h10, 8'h40};
	logic [5:0] wv [3] = '{6'h17, 6'h18, 6'h11};
	lcai_top lcai_top_inst (.sys_clk(sys_clk), .rst_b(rst_b),
		.host_req(req), .host_rdata(rdata), .alarm_in(alarm),
		.fifo_wr_ptr(wp), .fifo_rd_ptr(rp), .transmit_clock(txc),
		.bit_error_flip(flip), .irq(irq));
	initial forever #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) nflip <= nflip + $countones(flip);
	task automatic close_out();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk) req <= '{1'b0, 1'b1, a, d};
		@(posedge sys_clk) req <= '0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e,
		input bit c = 1'b1);
		@(posedge sys_clk) req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge sys_clk) req <= '0;
		#1 if (c) chk(rdata, e);
	endtask
	task automatic wirq(input logic e);
		int i;
		for (i = 0; i < 8 && irq !== e; i++)
			@(posedge sys_clk);
		#1 chk({7'h00, irq}, {7'h00, e});
		if (irq !== e)
			close_out();
	endtask
	task automatic txp();
		@(posedge sys_clk) txc <= '1;
		repeat (2) @(posedge sys_clk);
		txc <= '0;
		repeat (2) @(posedge sys_clk);
	endtask
	initial begin
		int i;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (i = 3; i < 7; i++)
			rc(8'(i), 8'h00);
		wr(8'h74, 8'hff);
		rc(8'h74, 8'h77);
		rc(8'h9f, 8'h00);
		wr(8'h74, 8'h00);
		for (i = 0; i < 6; i++) begin
			@(posedge sys_clk) alarm[0] <= 6'h01 << i;
			rc(8'h05, exp_st[i]);
		end
		@(posedge sys_clk) alarm[0] <= 6'h10;
		wr(8'h81, 8'h80);
		rc(8'h81, 8'h80);
		rc(8'h05, 8'h00);
		@(posedge sys_clk) alarm[0] <= 6'h08;
		rc(8'h05, 8'h10);
		wr(8'h81, 8'h00);
		rc(8'h05, 8'h00);
		@(posedge sys_clk) alarm[0] <= 6'h00;
		for (i = 0; i < 3; i++) begin
			@(posedge sys_clk) wp[0] <= wv[i];
			rc(8'h05, i == 1 ? 8'h00 : 8'h20);
		end
		for (i = 0; i < 8; i++)
			rc({i[3:0], 4'h6}, 8'h00, 1'b0);
		wr(8'h24, 8'h04);
		wr(8'h80, 8'h02);
		@(posedge sys_clk) alarm[2] <= 6'h04;
		wirq(1'b1);
		rc(8'h26, 8'h04);
		rc(8'h26, 8'h00);
		wirq(1'b0);
		wr(8'h24, 8'h00);
		@(posedge sys_clk) alarm[2] <= 6'h00;
		repeat (4) @(posedge sys_clk);
		#1 chk({7'h00, irq}, 8'h00);
		wr(8'h24, 8'h04);
		wirq(1'b1);
		wr(8'h80, 8'h00);
		wirq(1'b0);
		wr(8'he0, 8'h02);
		wirq(1'b1);
		for (i = 1; i < 3; i++) begin
			wr(8'h03, 8'h00);
			wr(8'h73, 8'h00);
			txp();
			wr(8'h03, 8'h02);
			wr(8'h73, 8'h02);
			txp();
			txp();
			chk(8'(nflip), 8'(2 * i));
		end
		rc(8'h73, 8'h02);
		@(posedge sys_clk) rst_b <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		rc(8'h73, 8'h00);
		rc(8'h24, 8'h00);
		rc(8'h80, 8'h00);
		chk({7'h00, irq}, 8'h00);
		close_out();
	end
endmodule
bind lcai_top lcai_top_props #(.NUM_CHAN(NUM_CHAN), .PTR_W(PTR_W))
	lcai_top_props_inst (.sys_clk(sys_clk), .rst_b(rst_b),
	.host_req(host_req), .host_rdata(host_rdata), .alarm_in(alarm_in),
	.fifo_wr_ptr(fifo_wr_ptr), .fifo_rd_ptr(fifo_rd_ptr),
	.transmit_clock(transmit_clock), .bit_error_flip(bit_error_flip),
	.irq(irq));

//--- verilog/lcai_cfg.svh
// Offsets, field positions, reset values and limits of the alarm block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef LCAI_CFG_SVH
`define LCAI_CFG_SVH

// ----------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------
`define LCAI_NUM_CHAN 8
`define LCAI_OFS_ERR_INS 4'h3
`define LCAI_OFS_IRQ_EN 4'h4
`define LCAI_OFS_STATUS 4'h5
`define LCAI_OFS_CHANGED 4'h6
`define LCAI_ADDR_GLOBAL 8'h80
`define LCAI_ADDR_GLOBAL_ALT 8'he0
`define LCAI_ADDR_GLOBAL2 8'h81

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LCAI_BIT_INS_ERR 1
`define LCAI_BIT_GIE 1
`define LCAI_BIT_OVF_SEL 7
`define LCAI_BIT_DRV 6
`define LCAI_BIT_FIFO 5
`define LCAI_BIT_VIOL 4
`define LCAI_BIT_AIS 2
`define LCAI_BIT_LOS 1
`define LCAI_BIT_PAT 0
`define LCAI_ALARM_MASK 8'h77

// ----------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------
`define LCAI_RESET_BYTE 8'h00
`define LCAI_FIFO_NEAR 3
`define LCAI_FIFO_PTR_W 6

`endif

//--- verilog/lcai_pkg.sv
// Types shared by the alarm block and its bench.
// Assumes the constants header is on the include path.
`include "lcai_cfg.svh"

package lcai_pkg;

	// Live alarm conditions of one channel.
	typedef struct packed {
		logic driver_fail;
		logic violation;
		logic counter_overflow;
		logic all_ones;
		logic signal_loss;
		logic pattern_detect;
	} lcai_alarm_in_type;

	// One cycle of the host microprocessor port.
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lcai_host_req_type;

endpackage

//--- verilog/lcai_top.sv
// Per-channel alarm status, interrupt masking and bit-error insertion.
// Assumes all inputs, transmit clocks included, are synchronous to sys_clk.
//
// What this block does
// [R1] A rising insert-bit-error bit corrupts exactly one transmitted test bit.
// [R2] The insert-bit-error bit is sampled on rising transmit clock edges.
// [R3] Software writes zero before one so a clean rising edge is seen.
// [R4] Enable register holds one mask bit per alarm at bits 6,5,4,2,1,0.
// [R5] Bits 7 and 3 of enable and status registers are unused.
// [R6] Interrupt asserts only with global enable and the alarm enable set.
// [R7] The six status bits track their conditions whatever the enables are.
// [R8] Driver flag reads one while the transmit driver has failed.
// [R9] FIFO flag reads one when pointers lie within three of each other.
// [R10] Violation flag shows counter overflow when global bit 7 is set.
// [R11] In violation mode the flag shows code, bipolar or zeros violations.
// [R12] All-ones flag reads one while all-ones is received.
// [R13] Signal-loss flag reads one while receive signal is lost.
// [R14] Pattern flag reads one while the test pattern is detected.
// [R15] Any status change sets a changed bit, which interrupts and reads clear.
// [R16] Channel n registers sit at channel 0 offset plus n times 0x10.
// [R17] After reset all enables, flags and the insert bit read zero.
`timescale 1ns/1ps
`include "lcai_cfg.svh"

module lcai_top #(
	parameter int NUM_CHAN = `LCAI_NUM_CHAN,
	parameter int PTR_W = `LCAI_FIFO_PTR_W
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Host microprocessor port
	input wire lcai_pkg::lcai_host_req_type host_req,
	output logic [7:0] host_rdata,
	// Receive alarm conditions and jitter FIFO pointers
	input wire lcai_pkg::lcai_alarm_in_type [NUM_CHAN-1:0] alarm_in,
	input wire logic [NUM_CHAN-1:0][PTR_W-1:0] fifo_wr_ptr,
	input wire logic [NUM_CHAN-1:0][PTR_W-1:0] fifo_rd_ptr,
	// Transmit side
	input wire logic [NUM_CHAN-1:0] transmit_clock,
	output logic [NUM_CHAN-1:0] bit_error_flip,
	// Interrupt
	output logic irq
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// True when the two FIFO pointers are within the limit either way.
	function automatic logic fifo_near(logic [PTR_W-1:0] wr,
		logic [PTR_W-1:0] rd);
		logic [PTR_W-1:0] ahead;
		logic [PTR_W-1:0] behind;
		ahead = wr - rd;
		behind = rd - wr;
		fifo_near = (ahead <= PTR_W'(`LCAI_FIFO_NEAR)) ||
			(behind <= PTR_W'(`LCAI_FIFO_NEAR));
	endfunction

	// Builds the status byte of one channel from its live conditions.
	function automatic logic [7:0] build_status(
		lcai_pkg::lcai_alarm_in_type a, logic near, logic ovf_sel);
		logic [7:0] s;
		s = `LCAI_RESET_BYTE;
		s[`LCAI_BIT_DRV] = a.driver_fail; // [R8]
		s[`LCAI_BIT_FIFO] = near; // [R9]
		s[`LCAI_BIT_VIOL] = ovf_sel ? a.counter_overflow : a.violation; // [R10]
		s[`LCAI_BIT_AIS] = a.all_ones; // [R12]
		s[`LCAI_BIT_LOS] = a.signal_loss; // [R13]
		s[`LCAI_BIT_PAT] = a.pattern_detect; // [R14]
		build_status = s & `LCAI_ALARM_MASK; // [R5]
	endfunction

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	logic [2:0] sel_chan;
	logic [3:0] sel_ofs;
	logic chan_hit;
	logic glob_hit;
	logic glob2_hit;

	assign sel_chan = host_req.addr[6:4]; // [R16]
	assign sel_ofs = host_req.addr[3:0];
	assign chan_hit = !host_req.addr[7] && (int'(sel_chan) < NUM_CHAN);
	assign glob_hit = (host_req.addr == `LCAI_ADDR_GLOBAL) ||
		(host_req.addr == `LCAI_ADDR_GLOBAL_ALT);
	assign glob2_hit = host_req.addr == `LCAI_ADDR_GLOBAL2;

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	logic [7:0] irq_enable [NUM_CHAN];
	logic [NUM_CHAN-1:0] insert_bit_error_bit;
	logic [7:0] alarm_status [NUM_CHAN];
	logic [7:0] changed_status [NUM_CHAN];
	logic global_irq_enable;
	logic overflow_select;
	logic [7:0] next_status [NUM_CHAN];
	logic [7:0] next_rdata;
	logic next_irq;

	// Software-written controls.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				irq_enable[i] <= `LCAI_RESET_BYTE; // [R17]
			end
			insert_bit_error_bit <= '0; // [R17]
			global_irq_enable <= 1'b0;
			overflow_select <= 1'b0;
		end else if (host_req.wr) begin
			if (chan_hit && sel_ofs == `LCAI_OFS_IRQ_EN) begin
				irq_enable[sel_chan] <= host_req.wdata & `LCAI_ALARM_MASK; // [R4]
			end
			if (chan_hit && sel_ofs == `LCAI_OFS_ERR_INS) begin
				insert_bit_error_bit[sel_chan] <=
					host_req.wdata[`LCAI_BIT_INS_ERR]; // [R3]
			end
			if (glob_hit) begin
				global_irq_enable <= host_req.wdata[`LCAI_BIT_GIE];
			end
			if (glob2_hit) begin
				overflow_select <= host_req.wdata[`LCAI_BIT_OVF_SEL];
			end
		end
	end

	// ------------------------------------------------------------------
	// Live alarm status and change capture
	// ------------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_CHAN; i++) begin
			next_status[i] = build_status(alarm_in[i],
				fifo_near(fifo_wr_ptr[i], fifo_rd_ptr[i]), overflow_select);
		end
	end

	// Status follows the conditions every cycle, masks play no part.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				alarm_status[i] <= `LCAI_RESET_BYTE; // [R17]
			end
		end else begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				alarm_status[i] <= next_status[i]; // [R7] [R11]
			end
		end
	end

	// Changed bits clear on read; a change in the same cycle wins.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				changed_status[i] <= `LCAI_RESET_BYTE;
			end
		end else begin
			for (int i = 0; i < NUM_CHAN; i++) begin
				if (host_req.rd && chan_hit && int'(sel_chan) == i &&
					sel_ofs == `LCAI_OFS_CHANGED) begin
					changed_status[i] <= next_status[i] ^ alarm_status[i]; // [R15]
				end else begin
					changed_status[i] <= changed_status[i] |
						(next_status[i] ^ alarm_status[i]); // [R15]
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------------
	always_comb begin
		next_irq = 1'b0;
		for (int i = 0; i < NUM_CHAN; i++) begin
			next_irq = next_irq | (|(changed_status[i] & irq_enable[i]));
		end
		next_irq = next_irq & global_irq_enable; // [R6]
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq; // [R6]
		end
	end

	// ------------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------------
	always_comb begin
		next_rdata = `LCAI_RESET_BYTE;
		if (chan_hit) begin
			case (sel_ofs)
				`LCAI_OFS_ERR_INS: begin
					next_rdata[`LCAI_BIT_INS_ERR] = insert_bit_error_bit[sel_chan];
				end
				`LCAI_OFS_IRQ_EN: begin
					next_rdata = irq_enable[sel_chan];
				end
				`LCAI_OFS_STATUS: begin
					next_rdata = alarm_status[sel_chan];
				end
				`LCAI_OFS_CHANGED: begin
					next_rdata = changed_status[sel_chan];
				end
				default: begin
					next_rdata = `LCAI_RESET_BYTE;
				end
			endcase
		end else if (glob_hit) begin
			next_rdata[`LCAI_BIT_GIE] = global_irq_enable;
		end else if (glob2_hit) begin
			next_rdata[`LCAI_BIT_OVF_SEL] = overflow_select;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			host_rdata <= `LCAI_RESET_BYTE;
		end else if (host_req.rd) begin
			host_rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------------
	// Bit-error insertion
	// ------------------------------------------------------------------
	logic [NUM_CHAN-1:0] transmit_clock_prev;
	logic [NUM_CHAN-1:0] insert_sampled;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			transmit_clock_prev <= '0;
			insert_sampled <= '0;
			bit_error_flip <= '0;
		end else begin
			transmit_clock_prev <= transmit_clock;
			for (int i = 0; i < NUM_CHAN; i++) begin
				if (transmit_clock[i] && !transmit_clock_prev[i]) begin
					insert_sampled[i] <= insert_bit_error_bit[i]; // [R2]
					bit_error_flip[i] <= insert_bit_error_bit[i] &&
						!insert_sampled[i]; // [R1]
				end else begin
					bit_error_flip[i] <= 1'b0;
				end
			end
		end
	end

endmodule
